// ### fpbs_top.sv
// fpbs_top.sv: custom-instruction slaves of the enhanced fp unit, the basic
// fp unit and the bit reversal unit
// assumes one custom instruction in flight at a time, as the master issues
`timescale 1ns/100ps
`include "fpbs_defs.svh"
module fpbs_top
  import fpbs_pkg::*;
#(
  parameter bit HAS_DIV = 1'b0,
  parameter bit HW_MUL  = 1'b1
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire fpbs_ops_t   cmb_ops_i,
  output logic [31:0]      cmb_result_o,
  input  wire fpbs_req_t   mc_req_i,
  output logic             mc_done_o,
  output logic [31:0]      mc_result_o,
  input  wire fpbs_req_t   bas_req_i,
  output logic             bas_done_o,
  output logic [31:0]      bas_result_o,
  input  wire logic [31:0] bsw_dataa_i,
  output logic [31:0]      bsw_result_o
);

  fpbs_eng_t e_q;
  fpbs_eng_t e_d;

  // ==========================================================
  // bit reversal: same-cycle slave, no state
  for (genvar g = 0; g < 32; g++) begin : g_bsw
    assign bsw_result_o[g] = bsw_dataa_i[31-g];
  end

  // ==========================================================
  // combinational slave of the enhanced unit
  // result is not registered: the master reads it in the same cycle
  fpbs_fpcmp u_cmp (
    .ops_i    (cmb_ops_i),
    .result_o (cmb_result_o)
  );

  // ==========================================================
  // opcode decode
  function automatic fpbs_op_t enh_op(input logic [7:0] n);
    case (n)
      `FPBS_M_ADD:  enh_op = FPBS_ADD;
      `FPBS_M_SUB:  enh_op = FPBS_SUB;
      `FPBS_M_MUL:  enh_op = FPBS_MUL;
      `FPBS_M_DIV:  enh_op = FPBS_DIV;
      `FPBS_M_SQRT: enh_op = FPBS_SQRT;
      `FPBS_M_I2F:  enh_op = FPBS_I2F;
      `FPBS_M_F2I:  enh_op = FPBS_F2I;
      default:      enh_op = FPBS_NOP;
    endcase
  endfunction

  function automatic fpbs_op_t bas_op(input logic [7:0] n);
    case (n)
      `FPBS_B_MUL: bas_op = FPBS_MUL;
      `FPBS_B_ADD: bas_op = FPBS_ADD;
      `FPBS_B_SUB: bas_op = FPBS_SUB;
      default:     bas_op = FPBS_DIV;
    endcase
  endfunction

  // ==========================================================
  // shared arithmetic engine
  // both multi-cycle slaves share it: the master never issues two at once
  always_comb begin
    fpbs_fp_t    a;
    fpbs_fp_t    b;
    fpbs_op_t    op;
    logic [31:0] raw;
    logic [31:0] res;
    logic [31:0] mag;
    logic [23:0] ma;
    logic [23:0] mv;
    logic [23:0] xm;
    logic [23:0] ym;
    logic [23:0] trial;
    logic [9:0]  ea;
    logic [9:0]  eb;
    logic [9:0]  ed;
    logic [9:0]  xe;
    logic [9:0]  ye;
    logic [47:0] al;
    logic [55:0] wide;
    logic        xs;
    logic        ys;
    logic        nf;
    logic        fin;
    logic        bsel;
    logic        mgo;
    logic        bgo;
    logic        qbit;
    e_d      = e_q;
    e_d.mdone = 1'b0;
    e_d.bdone = 1'b0;
    fin      = 1'b0;
    res      = 32'h0000_0000;
    mag      = 32'h0000_0000;
    wide     = '0;
    al       = '0;
    trial    = '0;
    qbit     = 1'b0;
    // extensions below each slave's range never start the engine; codes above FPBS_M_F2I do start it
    mgo  = mc_req_i.start && (mc_req_i.ops.n >= `FPBS_M_ADD);
    bgo  = bas_req_i.start && (bas_req_i.ops.n >= `FPBS_B_MUL)
           && (HAS_DIV || (bas_req_i.ops.n != `FPBS_B_DIV));
    bsel = !mgo;
    raw  = bsel ? bas_req_i.ops.dataa : mc_req_i.ops.dataa;
    a    = raw;
    b    = bsel ? bas_req_i.ops.datab : mc_req_i.ops.datab;
    op   = bsel ? bas_op(bas_req_i.ops.n) : enh_op(mc_req_i.ops.n);
    // denormals flush to zero
    ma   = (a.exp != 8'h00) ? {1'b1, a.man} : 24'h00_0000;
    mv   = (b.exp != 8'h00) ? {1'b1, b.man} : 24'h00_0000;
    ea   = {2'b00, a.exp};
    eb   = {2'b00, b.exp};
    nf   = (a.exp == 8'hFF) || (b.exp == 8'hFF);
    ys   = b.sign ^ (op == FPBS_SUB);
    // larger magnitude goes first so subtraction never wraps
    if ({a.exp, a.man} >= {b.exp, b.man}) begin
      xm = ma; ym = mv; xe = ea; ye = eb; xs = a.sign;
    end else begin
      xm = mv; ym = ma; xe = eb; ye = ea; xs = ys; ys = a.sign;
    end
    ed   = xe - ye;
    unique case (e_q.st)
      ST_IDLE: begin
        if (mgo || bgo) begin
          e_d.own = bsel;
          e_d.op  = op;
          e_d.cnt = 5'h00;
          e_d.m   = '0;
          e_d.mb  = mv;
          e_d.r   = {24'h00_0000, ma};
          e_d.sgn = a.sign ^ b.sign;
          case (op)
            FPBS_ADD, FPBS_SUB: begin
              if (nf) begin
                fin = 1'b1;
                res = `FPBS_QNAN;
              end else begin
                if (ed <= 10'h02F) al = {1'b0, ym, 23'h00_0000} >> ed;
                e_d.m   = (xs == ys) ? {1'b0, xm, 23'h00_0000} + al
                                     : {1'b0, xm, 23'h00_0000} - al;
                e_d.ex  = xe + 10'h001;
                e_d.sgn = xs;
                e_d.st  = ST_NORM;
              end
            end
            FPBS_MUL: begin
              e_d.ex = ea + eb - `FPBS_BIAS + 10'h001;
              if (nf) begin
                fin = 1'b1;
                res = `FPBS_QNAN;
              end else if (HW_MUL) begin
                e_d.m  = 48'(ma) * 48'(mv);
                e_d.st = ST_NORM;
              end else begin
                e_d.st = ST_CALC;
              end
            end
            FPBS_DIV: begin
              e_d.ex = ea - eb + `FPBS_BIAS;
              if (nf) begin
                fin = 1'b1;
                res = `FPBS_QNAN;
              end else if (mv == 24'h00_0000) begin
                fin = 1'b1;
                res = {e_d.sgn, `FPBS_INF};
              end else begin
                e_d.st = ST_CALC;
              end
            end
            FPBS_SQRT: begin
              ed     = ea - `FPBS_BIAS;
              e_d.r  = ed[0] ? {ma, 24'h00_0000} : {1'b0, ma, 23'h00_0000};
              ed     = ed - {9'h000, ed[0]};
              e_d.ex = {ed[9], ed[9:1]} + `FPBS_BIAS;
              e_d.mb = 24'h00_0000;
              e_d.sgn = 1'b0;
              if (a.exp == 8'hFF || (a.sign && ma != 24'h00_0000)) begin
                fin = 1'b1;
                res = `FPBS_QNAN;
              end else if (ma == 24'h00_0000) begin
                fin = 1'b1;
              end else begin
                e_d.st = ST_CALC;
              end
            end
            FPBS_I2F: begin
              mag     = raw[31] ? 32'h0000_0000 - raw : raw;
              e_d.m   = {mag, 16'h0000};
              e_d.ex  = `FPBS_I2F_EXP;
              e_d.sgn = raw[31];
              e_d.st  = ST_NORM;
            end
            FPBS_F2I: begin
              fin = 1'b1;
              ed  = ea - `FPBS_BIAS;
              if (a.exp == 8'h00 || ed[9]) begin
                res = 32'h0000_0000;
              end else if (ed > 10'h01E) begin
                res = a.sign ? 32'h8000_0000 : 32'h7FFF_FFFF;          // saturate
              end else begin
                wide = {32'h0000_0000, ma} << ed;
                mag  = wide[54:23];
                res  = a.sign ? 32'h0000_0000 - mag : mag;
              end
            end
            default: fin = 1'b1;        // unassigned enhanced codes answer zero
          endcase
        end
      end
      ST_CALC: begin
        e_d.cnt = e_q.cnt + 5'h01;
        case (e_q.op)
          FPBS_MUL: begin
            // shift-add when no hardware multiplier is wanted
            if (e_q.r[0]) e_d.m = e_q.m + (48'(e_q.mb) << e_q.cnt);
            e_d.r = e_q.r >> 1;
            if (e_q.cnt == `FPBS_MUL_LAST) e_d.st = ST_NORM;
          end
          FPBS_DIV: begin
            qbit  = (e_q.r >= 48'(e_q.mb));
            e_d.r = (qbit ? e_q.r - 48'(e_q.mb) : e_q.r) << 1;
            e_d.m = {e_q.m[46:0], qbit};
            if (e_q.cnt == `FPBS_DIV_LAST) begin
              e_d.m  = {e_q.m[23:0], qbit, 23'h00_0000};
              e_d.st = ST_NORM;
            end
          end
          FPBS_SQRT: begin
            trial = e_q.mb | (24'h80_0000 >> e_q.cnt);
            if (48'(trial) * 48'(trial) <= e_q.r) e_d.mb = trial;
            if (e_q.cnt == `FPBS_SQRT_LAST) begin
              e_d.m  = {e_d.mb, 24'h00_0000};
              e_d.st = ST_NORM;
            end
          end
          default: e_d.st = ST_NORM;
        endcase
      end
      ST_NORM: begin
        // one left shift per cycle until the leading one reaches bit 47
        if (e_q.m == 48'h0000_0000_0000) begin
          fin = 1'b1;
          res = {e_q.sgn, 31'h0000_0000};
        end else if (e_q.m[47]) begin
          fin = 1'b1;
          if (e_q.ex[9] || e_q.ex == 10'h000) begin
            res = {e_q.sgn, 31'h0000_0000};
          end else if (e_q.ex[8:0] >= 9'h0FF) begin
            res = {e_q.sgn, `FPBS_INF};
          end else begin
            res = {e_q.sgn, e_q.ex[7:0], e_q.m[46:24]};
          end
        end else begin
          e_d.m  = e_q.m << 1;
          e_d.ex = e_q.ex - 10'h001;
        end
      end
      ST_HOLD: e_d.st = ST_IDLE;  // lets the master drop start before re-arm
    endcase
    if (fin) begin
      e_d.st = ST_HOLD;
      if (e_d.own) begin
        e_d.bres  = res;
        e_d.bdone = 1'b1;
      end else begin
        e_d.mres  = res;
        e_d.mdone = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      e_q <= '0;
    end else begin
      e_q <= e_d;
    end
  end

  assign mc_done_o    = e_q.mdone;
  assign mc_result_o  = e_q.mres;
  assign bas_done_o   = e_q.bdone;
  assign bas_result_o = e_q.bres;

  // ==========================================================
  // checks
  logic [31:0] bsw_ref;
  always_comb bsw_ref = {<<{bsw_dataa_i}};

  a_bswap_order: assert property (@(posedge clock_i) disable iff (!nrst_i)
    bsw_result_o == bsw_ref) else $error("bit reversal mismatch");

  a_cmb_negate: assert property (@(posedge clock_i) disable iff (!nrst_i)
    cmb_ops_i.n == `FPBS_C_NEG |-> (cmb_result_o ^ cmb_ops_i.dataa) == 32'h8000_0000)
    else $error("negate result wrong");

  a_cmb_abs_val: assert property (@(posedge clock_i) disable iff (!nrst_i)
    cmb_ops_i.n == `FPBS_C_ABS |-> cmb_result_o == {1'b0, cmb_ops_i.dataa[30:0]})
    else $error("abs result wrong");

  a_cmb_out_range: assert property (@(posedge clock_i) disable iff (!nrst_i)
    cmb_ops_i.n < `FPBS_ENH_LO |-> cmb_result_o == 32'h0000_0000)
    else $error("comb slave answered foreign code");

  a_mc_done_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i)
    mc_done_o |=> !mc_done_o && $stable(mc_result_o))
    else $error("mc done longer than one cycle");

  a_mc_ignore_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
    e_q.st == ST_IDLE && mc_req_i.start && mc_req_i.ops.n < `FPBS_M_ADD && !bas_req_i.start
    |=> !mc_done_o [*3]) else $error("mc slave took foreign code");

  a_bas_ignore_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
    e_q.st == ST_IDLE && bas_req_i.start && bas_req_i.ops.n < `FPBS_B_MUL && !mc_req_i.start
    |=> !bas_done_o [*3]) else $error("basic slave took foreign code");

  a_bas_no_div: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !HAS_DIV && e_q.st == ST_IDLE && bas_req_i.start && bas_req_i.ops.n == `FPBS_B_DIV
    && !mc_req_i.start |=> !bas_done_o [*3]) else $error("division ran while omitted");

  a_mc_mul_bound: assert property (@(posedge clock_i) disable iff (!nrst_i)
    e_q.st == ST_IDLE && mc_req_i.start && mc_req_i.ops.n == `FPBS_M_MUL
    |-> ##[1:40] mc_done_o) else $error("multiply did not finish");

  a_bas_add_bound: assert property (@(posedge clock_i) disable iff (!nrst_i)
    e_q.st == ST_IDLE && bas_req_i.start && bas_req_i.ops.n == `FPBS_B_ADD && !mc_req_i.start
    |-> ##[1:60] bas_done_o) else $error("basic add did not finish");

endmodule // fpbs_top

// ### fpbs_defs.svh
// fpbs_defs.svh: opcode extension values and step counts of the fp
// custom-instruction slaves; definitions only
`ifndef FPBS_DEFS_SVH
`define FPBS_DEFS_SVH

// ==========================================================
// enhanced unit, combinational slave
`define FPBS_ENH_LO    8'hE0
`define FPBS_C_MIN     8'hE0
`define FPBS_C_MAX     8'hE1
`define FPBS_C_LT      8'hE2
`define FPBS_C_EQ      8'hE3
`define FPBS_C_LE      8'hE4
`define FPBS_C_GT      8'hE5
`define FPBS_C_NEG     8'hE6
`define FPBS_C_ABS     8'hE7
`define FPBS_C_LAST    8'hE7

// ==========================================================
// enhanced unit, multi-cycle slave
`define FPBS_M_ADD     8'hE8
`define FPBS_M_SUB     8'hE9
`define FPBS_M_MUL     8'hEA
`define FPBS_M_DIV     8'hEB
`define FPBS_M_SQRT    8'hEC
`define FPBS_M_I2F     8'hED
`define FPBS_M_F2I     8'hEE

// ==========================================================
// basic unit, fixed extensions
`define FPBS_B_MUL     8'hFC
`define FPBS_B_ADD     8'hFD
`define FPBS_B_SUB     8'hFE
`define FPBS_B_DIV     8'hFF

// ==========================================================
// format constants and iteration counts (last step index)
`define FPBS_BIAS      10'h07F
`define FPBS_I2F_EXP   10'h09E
`define FPBS_QNAN      32'h7FC0_0000
`define FPBS_INF       31'h7F80_0000
`define FPBS_MUL_LAST  5'h17
`define FPBS_DIV_LAST  5'h18
`define FPBS_SQRT_LAST 5'h17

`endif

// ### fpbs_pkg.sv
// fpbs_pkg.sv: types shared by the fp and bitswap slaves
// no dependencies
package fpbs_pkg;

  typedef struct packed {
    logic        sign;
    logic [7:0]  exp;
    logic [22:0] man;
  } fpbs_fp_t;

  typedef struct packed {
    logic [31:0] dataa;
    logic [31:0] datab;
    logic [7:0]  n;
  } fpbs_ops_t;

  typedef struct packed {
    fpbs_ops_t ops;
    logic      start;
  } fpbs_req_t;

  typedef enum logic [2:0] {
    FPBS_NOP, FPBS_ADD, FPBS_SUB, FPBS_MUL,
    FPBS_DIV, FPBS_SQRT, FPBS_I2F, FPBS_F2I
  } fpbs_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_NORM, ST_HOLD} fpbs_st_t;

  typedef struct packed {
    fpbs_st_t    st;
    fpbs_op_t    op;
    logic        own;
    logic        sgn;
    logic [9:0]  ex;
    logic [47:0] m;
    logic [47:0] r;
    logic [23:0] mb;
    logic [4:0]  cnt;
    logic [31:0] mres;
    logic [31:0] bres;
    logic        mdone;
    logic        bdone;
  } fpbs_eng_t;

endpackage

// ### fpbs_fpcmp.sv
// fpbs_fpcmp.sv: combinational min/max/compare/negate/abs of single floats
// purely combinational; the caller decodes nothing beyond passing n
`timescale 1ns/100ps
`include "fpbs_defs.svh"
module fpbs_fpcmp
  import fpbs_pkg::*;
(
  input  wire fpbs_ops_t   ops_i,
  output logic [31:0]      result_o
);

  fpbs_fp_t    a;
  fpbs_fp_t    b;
  logic [31:0] ka;
  logic [31:0] kb;
  logic        nan_a;
  logic        nan_b;
  logic        zz;
  logic        lt;
  logic        eq;

  // ==========================================================
  // ordering keys
  always_comb begin
    a     = ops_i.dataa;
    b     = ops_i.datab;
    nan_a = (a.exp == 8'hFF) && (a.man != 23'h00_0000);
    nan_b = (b.exp == 8'hFF) && (b.man != 23'h00_0000);
    // flip negatives so that plain unsigned compare orders floats
    ka    = a.sign ? ~ops_i.dataa : {1'b1, ops_i.dataa[30:0]};
    kb    = b.sign ? ~ops_i.datab : {1'b1, ops_i.datab[30:0]};
    zz    = (ops_i.dataa[30:0] == 31'h0000_0000) && (ops_i.datab[30:0] == 31'h0000_0000);
    // nan never compares true
    eq    = !nan_a && !nan_b && (zz || (ka == kb));
    lt    = !nan_a && !nan_b && !zz && (ka < kb);
  end

  // ==========================================================
  // operation select
  always_comb begin
    result_o = 32'h0000_0000;
    case (ops_i.n)
      `FPBS_C_MIN: result_o = (nan_a || (!nan_b && !lt)) ? ops_i.datab : ops_i.dataa;
      `FPBS_C_MAX: result_o = (nan_a || (!nan_b && lt)) ? ops_i.datab : ops_i.dataa;
      `FPBS_C_LT:  result_o = {31'h0000_0000, lt};
      `FPBS_C_EQ:  result_o = {31'h0000_0000, eq};
      `FPBS_C_LE:  result_o = {31'h0000_0000, lt || eq};
      `FPBS_C_GT:  result_o = {31'h0000_0000, !lt && !eq && !nan_a && !nan_b};
      `FPBS_C_NEG: result_o = {~a.sign, ops_i.dataa[30:0]};
      `FPBS_C_ABS: result_o = {1'b0, ops_i.dataa[30:0]};
      default:     result_o = 32'h0000_0000;
    endcase
  end

endmodule // fpbs_fpcmp

// ### fpbs_cim.sv
// fpbs_cim.sv: processor-side model of one multi-cycle custom-instruction master
// assumes a slave that pulses done for one cycle off the rising edge of clock_i
`timescale 1ns/100ps
module fpbs_cim
  import fpbs_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic done_i,
  output fpbs_req_t req_o
);
  int gap = 0;

  initial req_o = '0;

  // ==========================================================
  // request driving
  // released operands show the inverse, so a stale read never matches by chance
  task automatic drop_req(input fpbs_ops_t ops);
    req_o <= '{ops: ~ops, start: 1'b0};
  endtask

  task automatic issue(input fpbs_ops_t ops);
    int n;
    n = 0;
    @(posedge clock_i);
    req_o <= '{ops: ops, start: 1'b1};
    do begin
      @(posedge clock_i);
      n++;
    end while (done_i !== 1'b1 && n < 200);
    drop_req(ops);
    // one hold cycle in the slave, so two edges before the next start
    repeat (2 + gap) @(posedge clock_i);
  endtask

  // start held on a code that the slave must not take
  task automatic hold(input fpbs_ops_t ops, input int len);
    @(posedge clock_i);
    req_o <= '{ops: ops, start: 1'b1};
    repeat (len) @(posedge clock_i);
    drop_req(ops);
    repeat (2) @(posedge clock_i);
  endtask
endmodule // fpbs_cim

// ### testbench.sv
// testbench.sv: self-checking bench of the fp and bitswap slaves
// assumes fpbs_top with basic-unit division left out and the hardware multiplier in place
`timescale 1ns/100ps
`include "fpbs_defs.svh"
module testbench
  import fpbs_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        nrst_i  = 1'b0;
  fpbs_ops_t   cmb_ops = '0;
  fpbs_req_t   mc_req;
  fpbs_req_t   bas_req;
  logic [31:0] bsw_a   = '0;
  logic [31:0] cmb_res, mc_res, bas_res, bsw_res;
  logic        mc_done, bas_done;
  logic        cmb_v   = 1'b0;
  int          fails   = 0;
  int          checks  = 0;
  int          cycles  = 0;
  integer      seed    = 32'h67b4_d467;
  logic [31:0] cmb_q[$], bsw_q[$], mc_q[$], bas_q[$];

  always #20 clock_i = ~clock_i;

  fpbs_top #(.HAS_DIV(1'b0), .HW_MUL(1'b1)) u_dut (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .cmb_ops_i    (cmb_ops),
    .cmb_result_o (cmb_res),
    .mc_req_i     (mc_req),
    .mc_done_o    (mc_done),
    .mc_result_o  (mc_res),
    .bas_req_i    (bas_req),
    .bas_done_o   (bas_done),
    .bas_result_o (bas_res),
    .bsw_dataa_i  (bsw_a),
    .bsw_result_o (bsw_res)
  );

  // one master model on each multi-cycle slave
  fpbs_cim u_mc  (.clock_i(clock_i), .done_i(mc_done),  .req_o(mc_req));
  fpbs_cim u_bas (.clock_i(clock_i), .done_i(bas_done), .req_o(bas_req));

  // ==========================================================
  // comparison and verdict
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [31:0] rev(input logic [31:0] x);
    for (int i = 0; i < 32; i++) rev[i] = x[31-i];
  endfunction

  // ==========================================================
  // stimulus helpers
  task automatic comb(input logic [7:0] n, input logic [31:0] a, b, exp);
    logic [31:0] r;
    @(posedge clock_i);
    r = $random(seed);
    cmb_ops <= '{dataa: a, datab: b, n: n};
    bsw_a   <= r;
    cmb_v   <= 1'b1;
    cmb_q.push_back(exp);
    bsw_q.push_back(rev(r));
  endtask

  task automatic mc_op(input logic [7:0] n, input logic [31:0] a, b, exp);
    mc_q.push_back(exp);
    u_mc.issue('{dataa: a, datab: b, n: n});
  endtask

  task automatic bas_op(input logic [7:0] n, input logic [31:0] a, b, exp);
    bas_q.push_back(exp);
    u_bas.issue('{dataa: a, datab: b, n: n});
  endtask

  // ==========================================================
  // result watchers
  always @(negedge clock_i) begin
    if (cmb_v) begin
      check("cmb_result_o", cmb_res, cmb_q.pop_front());
      check("bsw_result_o", bsw_res, bsw_q.pop_front());
    end
  end

  // a done with no note waiting also catches a two-cycle pulse
  always @(posedge clock_i) begin
    cycles++;
    if (mc_done === 1'b1) begin
      if (mc_q.size() == 0) check("mc_done_o", 32'h0000_0001, 32'h0000_0000);
      else check("mc_result_o", mc_res, mc_q.pop_front());
    end
    if (bas_done === 1'b1) begin
      if (bas_q.size() == 0) check("bas_done_o", 32'h0000_0001, 32'h0000_0000);
      else check("bas_result_o", bas_res, bas_q.pop_front());
    end
    if (cycles == 6000) begin
      fails++;
      close_out();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(negedge clock_i);
    check("mc_result_o", mc_res, 32'h0000_0000);
    check("bas_done_o", {31'h0, bas_done}, 32'h0000_0000);
    comb(`FPBS_C_MIN, 32'h3FC0_0000, 32'h4010_0000, 32'h3FC0_0000);
    comb(`FPBS_C_MIN, 32'hC010_0000, 32'h3FC0_0000, 32'hC010_0000);
    comb(`FPBS_C_MAX, 32'h3FC0_0000, 32'h4010_0000, 32'h4010_0000);
    comb(`FPBS_C_LT,  32'h3FC0_0000, 32'h4010_0000, 32'h0000_0001);
    comb(`FPBS_C_EQ,  32'h3FC0_0000, 32'h4010_0000, 32'h0000_0000);
    comb(`FPBS_C_EQ,  32'h0000_0000, 32'h8000_0000, 32'h0000_0001);
    comb(`FPBS_C_LE,  32'h3FC0_0000, 32'h4010_0000, 32'h0000_0001);
    comb(`FPBS_C_GT,  32'h3FC0_0000, 32'h4010_0000, 32'h0000_0000);
    comb(`FPBS_C_NEG, 32'h3FC0_0000, 32'h0000_0000, 32'hBFC0_0000);
    comb(`FPBS_C_ABS, 32'hBFC0_0000, 32'h0000_0000, 32'h3FC0_0000);
    comb(`FPBS_M_ADD, 32'h3FC0_0000, 32'h4010_0000, 32'h0000_0000);
    comb(8'hDF,       32'h3FC0_0000, 32'h4010_0000, 32'h0000_0000);
    @(posedge clock_i);
    cmb_v <= 1'b0;
    mc_op(`FPBS_M_ADD,  32'h3FC0_0000, 32'h4010_0000, 32'h4070_0000);
    mc_op(`FPBS_M_SUB,  32'h4010_0000, 32'h3FC0_0000, 32'h3F40_0000);
    mc_op(`FPBS_M_MUL,  32'h3FC0_0000, 32'h4000_0000, 32'h4040_0000);
    mc_op(`FPBS_M_DIV,  32'h4040_0000, 32'h3FC0_0000, 32'h4000_0000);
    mc_op(`FPBS_M_SQRT, 32'h4080_0000, 32'h0000_0000, 32'h4000_0000);
    mc_op(`FPBS_M_I2F,  32'h0000_0005, 32'h0000_0000, 32'h40A0_0000);
    mc_op(`FPBS_M_F2I,  32'h4070_0000, 32'h0000_0000, 32'h0000_0003);
    u_mc.gap = 5;
    mc_op(`FPBS_M_ADD,  32'h7F80_0000, 32'h3FC0_0000, 32'h7FC0_0000);
    mc_op(`FPBS_M_DIV,  32'hBFC0_0000, 32'h0000_0000, 32'hFF80_0000);
    u_mc.hold('{dataa: 32'h3FC0_0000, datab: 32'h4010_0000, n: `FPBS_C_MIN}, 40);
    bas_op(`FPBS_B_MUL, 32'h3FC0_0000, 32'h4000_0000, 32'h4040_0000);
    bas_op(`FPBS_B_ADD, 32'h3FC0_0000, 32'h4010_0000, 32'h4070_0000);
    bas_op(`FPBS_B_SUB, 32'h4010_0000, 32'h3FC0_0000, 32'h3F40_0000);
    u_bas.hold('{dataa: 32'h4040_0000, datab: 32'h3FC0_0000, n: `FPBS_B_DIV}, 60);
    u_bas.hold('{dataa: 32'h3FC0_0000, datab: 32'h4010_0000, n: `FPBS_M_ADD}, 40);
    bas_op(`FPBS_B_ADD, 32'h4070_0000, 32'hBFC0_0000, 32'h4010_0000);
    check("mc_q empty", mc_q.size(), 32'h0000_0000);
    check("bas_q empty", bas_q.size(), 32'h0000_0000);
    close_out();
  end
endmodule // testbench
